// File: hw/adc_trig_consts.svh
// Constants for the conversion trigger control: fields, resets,
// trigger codes and timing counts. Assumes a 40 MHz system clock.
`ifndef ADC_TRIG_CONSTS_SVH
`define ADC_TRIG_CONSTS_SVH

// Register field layout and reset value
`define TRIG_SEL_MSB        4
`define TRIG_SEL_RESET      8'h00

// Trigger select codes
`define TRIG_CODE_OFF       5'h00
`define TRIG_CODE_FIRST     5'h01
`define TRIG_CODE_LAST      5'h18
`define TRIG_CODE_RD_ERR    5'h1c
`define TRIG_CODE_RD_RESH   5'h1d
`define TRIG_CODE_RD_CHAN   5'h1f
`define TRIG_SRC_COUNT      24

// Timing: clock period, extra start delay on the RC clock, conversion length
`define SYS_CLK_PERIOD_NS   25
`define RC_START_DELAY_NS   100
`define RC_START_CYCLES     ((`RC_START_DELAY_NS + `SYS_CLK_PERIOD_NS - 1) \
                             / `SYS_CLK_PERIOD_NS)
`define CONV_CYCLES         11

`endif

// File: hw/adc_trig_ctrl.sv
// Device end: start-of-conversion control with auto-trigger selection.
// Assumes the link interface carries software and peripheral signals on
// the system clock; the analog conversion is modelled as a fixed count.
//
// What this block does
// - In Sleep with RC clock, convert, flag done.
// - Sleep on other clock: hold pending until wake.
// - Rising edge of selected source sets go.
// - Source chosen by five-bit select field.
// - Code zero disables; code one selects pin.
// - Codes two to eight pick timer events.
// - Codes nine to 0x18 pick other peripherals.
// - Codes 0x1c/1d/1f fire on register reads.
// - Software avoids reserved trigger codes.
// - Software keeps trigger rate within timing.
// - Software configures and enables before setting go.
// - Zero acquisition setting: software waits first.
// - Completion visible in go and done flag.
// - Software clears done flag after result read.
// - Acquisition must finish after channel change.
// - Done flag set after every conversion.
// - Go cleared at completion unless continuous.
// - RC clock adds one instruction-cycle start delay.
`timescale 1ns/1ps
`include "adc_trig_consts.svh"

module adc_trig_ctrl #(
  parameter int CONV_LEN  = `CONV_CYCLES,
  parameter int RC_DELAY  = `RC_START_CYCLES
) (
  // Link to software and peripherals
  adc_trig_if.device            link,
  // Observation
  output logic                  o_conv_start,
  output adc_trig_pkg::conv_state_t o_state
);
  import adc_trig_pkg::*;

  localparam int CW = 8;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [`TRIG_SEL_MSB:0]  sel_reg;
  logic [23:0]             sync1_reg;
  logic [23:0]             sync2_reg;
  logic                    src_prev_reg;
  logic                    go_reg;
  logic                    go_next;
  logic                    done_reg;
  logic                    done_next;
  logic [CW-1:0]           cnt_reg;
  logic [CW-1:0]           cnt_next;
  conv_state_t             state_reg;
  conv_state_t             state_next;

  ////////////////////////////////////////////////////////////////////////
  // Trigger select register; upper bits read as zero
  always_ff @(posedge link.clk) begin
    if (link.rst) begin
      sel_reg <= 5'(`TRIG_SEL_RESET); // Only the kept field resets
    end else if (link.sel_wr) begin
      sel_reg <= link.sel_wdata[`TRIG_SEL_MSB:0];
    end
  end

  assign link.sel_rdata = {3'h0, sel_reg};

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser per source; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < `TRIG_SRC_COUNT; g = g + 1) begin : g_sync
      always_ff @(posedge link.clk) begin
        if (link.rst) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= link.trig_src[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Source selection: codes 1..0x18 index the synchronised levels
  wire        sel_is_src  = (sel_reg >= `TRIG_CODE_FIRST) &&
                            (sel_reg <= `TRIG_CODE_LAST);
  wire [4:0]  src_index   = sel_reg - 5'h01;
  wire        src_level   = sel_is_src & sync2_reg[src_index];
  wire        src_rise    = src_level & ~src_prev_reg;

  // Register-read triggers come from same-clock logic; no sync needed
  wire        rd_fire = ((sel_reg == `TRIG_CODE_RD_ERR)  & link.rd_err_pulse)
                      | ((sel_reg == `TRIG_CODE_RD_RESH) & link.rd_resh_pulse)
                      | ((sel_reg == `TRIG_CODE_RD_CHAN) & link.rd_chan_pulse);
  wire        trig_fire = src_rise | rd_fire;

  always_ff @(posedge link.clk) begin
    if (link.rst) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start and completion decode
  // A sleeping device on the system clock cannot convert, so go stays set
  // and the request waits as pending until Sleep ends.
  wire can_run   = link.module_on & (~link.in_sleep | link.rc_clk_sel);
  wire in_idle   = (state_reg == ST_IDLE);
  wire start     = in_idle & go_reg & can_run;
  wire finish    = (state_reg == ST_CONVERT) && (cnt_reg == 8'h00);
  wire abort     = ~in_idle & (~go_reg | ~link.module_on);

  assign link.pending = in_idle & go_reg & link.module_on &
                        link.in_sleep & ~link.rc_clk_sel;

  ////////////////////////////////////////////////////////////////////////
  // Go bit: any set beats the completion clear
  always_comb begin
    go_next = go_reg;
    if (link.go_clr | (finish & ~link.cont_mode)) begin
      go_next = 1'b0;
    end
    if (link.go_set | trig_fire) begin
      go_next = 1'b1;
    end
  end

  // Done flag: set on every completion, set wins over software clear
  always_comb begin
    done_next = done_reg;
    if (link.done_clr) begin
      done_next = 1'b0;
    end
    if (finish) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge link.clk) begin
    if (link.rst) begin
      go_reg   <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      go_reg   <= go_next;
      done_reg <= done_next;
    end
  end

  assign link.conversion_go        = go_reg;
  assign link.conversion_done_flag = done_reg;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: optional RC start delay, then fixed conversion count
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start && link.rc_clk_sel) begin
          state_next = ST_DELAY;
          cnt_next   = CW'(RC_DELAY - 1);
        end else if (start) begin
          state_next = ST_CONVERT;
          cnt_next   = CW'(CONV_LEN - 1);
        end
      end
      ST_DELAY: begin
        if (abort) begin
          state_next = ST_IDLE;
        end else if (cnt_reg == 8'h00) begin
          state_next = ST_CONVERT;
          cnt_next   = CW'(CONV_LEN - 1);
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      ST_CONVERT: begin
        if (abort || finish) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = 8'h00;
      end
    endcase
  end

  always_ff @(posedge link.clk) begin
    if (link.rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Continuous mode returns to idle with go still set, so it restarts
  assign link.busy    = ~in_idle;
  assign o_conv_start = start;
  assign o_state      = state_reg;

endmodule // adc_trig_ctrl

// File: hw/adc_trig_host.sv
// Far end: software register port and peripheral trigger levels.
// Assumes user-side inputs are on the system clock; all link outputs
// are registered one cycle.
`timescale 1ns/1ps
`include "adc_trig_consts.svh"

module adc_trig_host (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Link to the device end
  adc_trig_if.host         link,
  // Peripheral trigger levels
  input  wire logic [23:0] i_trig_src,
  // Software commands, one-cycle pulses
  input  wire logic        i_sel_wr,
  input  wire logic [7:0]  i_sel_wdata,
  input  wire logic        i_go_set,
  input  wire logic        i_go_clr,
  input  wire logic        i_done_clr,
  input  wire logic        i_rd_err,
  input  wire logic        i_rd_resh,
  input  wire logic        i_rd_chan,
  // Software configuration levels
  input  wire logic        i_module_on,
  input  wire logic        i_rc_clk_sel,
  input  wire logic        i_cont_mode,
  input  wire logic        i_in_sleep,
  // Status back to software
  output logic [7:0]       o_sel_rdata,
  output logic             o_conversion_go,
  output logic             o_conversion_done_flag,
  output logic             o_busy,
  output logic             o_pending
);
  import adc_trig_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Drive link from flops; software must configure before setting go
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      link.trig_src      <= 24'h000000;
      link.sel_wr        <= 1'b0;
      link.sel_wdata     <= 8'h00;
      link.go_set        <= 1'b0;
      link.go_clr        <= 1'b0;
      link.done_clr      <= 1'b0;
      link.rd_err_pulse  <= 1'b0;
      link.rd_resh_pulse <= 1'b0;
      link.rd_chan_pulse <= 1'b0;
      link.module_on     <= 1'b0;
      link.rc_clk_sel    <= 1'b0;
      link.cont_mode     <= 1'b0;
      link.in_sleep      <= 1'b0;
    end else begin
      link.trig_src      <= i_trig_src;
      link.sel_wr        <= i_sel_wr;
      link.sel_wdata     <= i_sel_wdata;
      link.go_set        <= i_go_set;
      link.go_clr        <= i_go_clr;
      link.done_clr      <= i_done_clr;
      link.rd_err_pulse  <= i_rd_err;
      link.rd_resh_pulse <= i_rd_resh;
      link.rd_chan_pulse <= i_rd_chan;
      link.module_on     <= i_module_on;
      link.rc_clk_sel    <= i_rc_clk_sel;
      link.cont_mode     <= i_cont_mode;
      link.in_sleep      <= i_in_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status capture for polling
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_sel_rdata            <= 8'h00;
      o_conversion_go        <= 1'b0;
      o_conversion_done_flag <= 1'b0;
      o_busy                 <= 1'b0;
      o_pending              <= 1'b0;
    end else begin
      o_sel_rdata            <= link.sel_rdata;
      o_conversion_go        <= link.conversion_go;
      o_conversion_done_flag <= link.conversion_done_flag;
      o_busy                 <= link.busy;
      o_pending              <= link.pending;
    end
  end

endmodule // adc_trig_host

// File: hw/adc_trig_if.sv
// Link between the trigger control and its software/peripheral side.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps

interface adc_trig_if (
  input wire logic clk,
  input wire logic rst
);
  logic [23:0] trig_src;      // Peripheral trigger levels, code-1 indexed
  logic        rd_err_pulse;  // Software read of error result register
  logic        rd_resh_pulse; // Software read of result high byte
  logic        rd_chan_pulse; // Software read of channel select register
  logic        sel_wr;        // Write strobe for trigger select
  logic [7:0]  sel_wdata;
  logic        go_set;        // Software sets conversion_go
  logic        go_clr;        // Software clears conversion_go (abort)
  logic        done_clr;      // Software clears conversion_done_flag
  logic        module_on;
  logic        rc_clk_sel;    // Conversion clock is dedicated_rc_clock
  logic        cont_mode;     // continuous_convert
  logic        in_sleep;
  logic [7:0]  sel_rdata;
  logic        conversion_go;
  logic        conversion_done_flag;
  logic        busy;
  logic        pending;

  modport device (
    input  clk, rst, trig_src, rd_err_pulse, rd_resh_pulse, rd_chan_pulse,
           sel_wr, sel_wdata, go_set, go_clr, done_clr, module_on,
           rc_clk_sel, cont_mode, in_sleep,
    output sel_rdata, conversion_go, conversion_done_flag, busy, pending
  );

  modport host (
    input  clk, rst, sel_rdata, conversion_go, conversion_done_flag, busy,
           pending,
    output trig_src, rd_err_pulse, rd_resh_pulse, rd_chan_pulse, sel_wr,
           sel_wdata, go_set, go_clr, done_clr, module_on, rc_clk_sel,
           cont_mode, in_sleep
  );
endinterface

// File: hw/adc_trig_pkg.sv
// Types shared by both ends of the conversion trigger link.
// Assumes the constants header is compiled alongside.
package adc_trig_pkg;

  // Conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_DELAY   = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;

  typedef logic [4:0] trig_code_t;

endpackage

// File: tb/adc_trig_chk.sv
// Assertions on the trigger link between host and device ends.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps

module adc_trig_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Host side requests
  input wire logic [23:0] trig_src,
  input wire logic        rd_err_pulse,
  input wire logic        rd_resh_pulse,
  input wire logic        rd_chan_pulse,
  input wire logic        sel_wr,
  input wire logic [7:0]  sel_wdata,
  input wire logic        go_set,
  input wire logic        go_clr,
  input wire logic        done_clr,
  input wire logic        module_on,
  input wire logic        rc_clk_sel,
  input wire logic        cont_mode,
  input wire logic        in_sleep,
  // Device side status
  input wire logic [7:0]  sel_rdata,
  input wire logic        conversion_go,
  input wire logic        conversion_done_flag,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // Decoded selection; reserved codes count as idle
  wire logic [4:0] code     = sel_rdata[4:0];
  wire logic       idle_sel = code inside {5'h00, [5'h19:5'h1b], 5'h1e};
  wire logic       read_hit = (rd_err_pulse && code == 5'h1c) ||
                              (rd_resh_pulse && code == 5'h1d) ||
                              (rd_chan_pulse && code == 5'h1f);

  ////////////////////////////////////////////////////////////////////////
  // A finish is a fall of busy that no abort, reset or new request explains
  sequence conv_end;
    $fell(busy) && $past(conversion_go) && !$past(go_clr) &&
    $past(module_on) && !$past(go_set) && !$past(rst);
  endsequence
  // Four quiet cycles cover the source synchroniser depth
  sequence quiet;
    (idle_sel && !go_set && !conversion_go)[*4];
  endsequence

  go_set_a: assert property (go_set |=> conversion_go)
    else $error("go not set after request");
  sel_store_a: assert property (sel_wr |=>
    sel_rdata == ($past(sel_wdata) & 8'h1f))
    else $error("select field not stored");
  read_fire_a: assert property (read_hit |=> conversion_go)
    else $error("register read did not fire");
  pin_fire_a: assert property (code >= 5'd1 && code <= 5'd24 &&
    $rose(trig_src[code - 5'd1]) |-> ##[1:5] conversion_go)
    else $error("selected source edge did not fire");
  idle_sel_a: assert property (quiet |=> !conversion_go)
    else $error("idle or reserved code fired");
  done_set_a: assert property (conv_end |-> conversion_done_flag)
    else $error("done flag missing at finish");
  go_clear_a: assert property (conv_end ##0 !$past(cont_mode)
    |-> !conversion_go)
    else $error("go not cleared at finish");
  cont_keep_a: assert property (conv_end ##0 $past(cont_mode)
    |-> conversion_go)
    else $error("go dropped in continuous mode");
  done_hold_a: assert property (conversion_done_flag && !done_clr
    |=> conversion_done_flag)
    else $error("done flag lost without clear");
  sleep_hold_a: assert property (in_sleep && !rc_clk_sel && !busy
    |=> !busy)
    else $error("conversion started in sleep");
  wake_run_a: assert property ($fell(in_sleep) && conversion_go &&
    module_on && !busy && !rc_clk_sel |-> ##[0:2] busy)
    else $error("pending start lost at wake");
  // Go lands one edge after the request, busy one edge later
  rc_sleep_a: assert property (go_set && module_on && !busy &&
    rc_clk_sel |-> ##2 busy)
    else $error("no start on dedicated clock");
endmodule // adc_trig_chk

// File: tb/testbench.sv
// Self-checking bench joining host and device ends over the link.
// Assumes 40 MHz clock; host adds one cycle of latency each way.
`timescale 1ns/1ps

module testbench;
  // Codes that fire a conversion, indexed by select code
  localparam logic [31:0] FIRES = 32'hb1ff_fffe;
  logic        i_sys_clk, i_reset, i_sel_wr, i_go_set, i_go_clr;
  logic        i_done_clr, i_rd_err, i_rd_resh, i_rd_chan, i_module_on;
  logic        i_rc_clk_sel, i_cont_mode, i_in_sleep, seen;
  logic        o_go, o_done, o_busy, o_pending;
  logic [23:0] i_trig_src, tb;
  logic [7:0]  i_sel_wdata, o_sel_rdata, stat;
  logic [6:0]  cmd;
  logic [2:0]  rb;
  int          n_fail, n_tests;

  // All one-cycle commands come from one vector; one pulse can carry several of them
  assign {i_sel_wr, i_rd_chan, i_rd_resh, i_rd_err} = cmd[6:3];
  assign {i_done_clr, i_go_clr, i_go_set} = cmd[2:0];
  assign stat = {3'h0, seen, o_go, o_done, o_busy, o_pending};

  adc_trig_if lnk (.clk(i_sys_clk), .rst(i_reset));
  adc_trig_host adc_trig_host_inst (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .link(lnk), .i_trig_src(i_trig_src),
    .i_sel_wr(i_sel_wr), .i_sel_wdata(i_sel_wdata), .i_go_set(i_go_set),
    .i_go_clr(i_go_clr), .i_done_clr(i_done_clr), .i_rd_err(i_rd_err),
    .i_rd_resh(i_rd_resh), .i_rd_chan(i_rd_chan),
    .i_module_on(i_module_on), .i_rc_clk_sel(i_rc_clk_sel),
    .i_cont_mode(i_cont_mode), .i_in_sleep(i_in_sleep),
    .o_sel_rdata(o_sel_rdata), .o_conversion_go(o_go),
    .o_conversion_done_flag(o_done), .o_busy(o_busy),
    .o_pending(o_pending));
  adc_trig_ctrl adc_trig_ctrl_inst (.link(lnk), .o_conv_start(),
    .o_state());
  adc_trig_chk adc_trig_chk_inst (.clk(lnk.clk), .rst(lnk.rst),
    .trig_src(lnk.trig_src), .rd_err_pulse(lnk.rd_err_pulse),
    .rd_resh_pulse(lnk.rd_resh_pulse), .rd_chan_pulse(lnk.rd_chan_pulse),
    .sel_wr(lnk.sel_wr), .sel_wdata(lnk.sel_wdata),
    .go_set(lnk.go_set), .go_clr(lnk.go_clr), .done_clr(lnk.done_clr),
    .module_on(lnk.module_on), .rc_clk_sel(lnk.rc_clk_sel),
    .cont_mode(lnk.cont_mode), .in_sleep(lnk.in_sleep),
    .sel_rdata(lnk.sel_rdata), .conversion_go(lnk.conversion_go),
    .conversion_done_flag(lnk.conversion_done_flag), .busy(lnk.busy));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge i_sys_clk) cmd <= m;
    @(posedge i_sys_clk) cmd <= 7'h00;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Raise sources and reads, then watch for a finished conversion
  task automatic fire(input logic [23:0] t, input logic [2:0] r,
                      input logic exp);
    seen = 1'b0;
    @(posedge i_sys_clk) i_trig_src <= t;
    if (r != 3'b000) pulse({1'b0, r, 3'b000});
    repeat (40) begin
      @(posedge i_sys_clk);
      if (o_done === 1'b1) seen = 1'b1;
    end
    chk(stat, {3'h0, exp, 1'b0, exp, 2'b00});
    i_trig_src <= 24'h0;
    pulse(7'h04);
    tick(3);
  endtask

  task automatic summarize;
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: about six times the expected run length
  initial begin
    tick(20000);
    n_fail++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_reset, cmd, i_sel_wdata, i_trig_src, seen} = {1'b1, 40'h0};
    {i_module_on, i_rc_clk_sel, i_cont_mode, i_in_sleep} = 4'b0000;
    n_fail = 0;
    n_tests = 0;
    tick(12);
    i_reset <= 1'b0;
    i_module_on <= 1'b1;
    tick(3);
    chk(stat, 8'h00);
    // Every code: others' edges must not fire, its own must where FIRES marks it
    for (int c = 0; c < 32; c++) begin
      tb = (c >= 1 && c <= 24) ? 24'h1 << (c - 1) : 24'h0;
      rb = c == 28 ? 3'b001 : c == 29 ? 3'b010 : c == 31 ? 3'b100 : 3'b0;
      i_sel_wdata <= {3'b111, c[4:0]};
      pulse(7'h40);
      tick(3);
      chk(o_sel_rdata, {3'h0, c[4:0]});
      fire(~tb, ~rb, 1'b0);
      fire(tb, rb, FIRES[c]);
    end
    seen = 1'b0;
    // Sleep on the system clock: start waits for wake
    i_sel_wdata <= 8'h00;
    pulse(7'h40);
    i_in_sleep <= 1'b1;
    tick(2);
    pulse(7'h01);
    tick(20);
    chk(stat, 8'h09);
    i_in_sleep <= 1'b0;
    tick(30);
    chk(stat, 8'h04);
    pulse(7'h04);
    // Sleep on the dedicated clock: converts while asleep
    {i_rc_clk_sel, i_in_sleep} <= 2'b11;
    tick(2);
    pulse(7'h01);
    tick(30);
    chk(stat, 8'h04);
    pulse(7'h04);
    // Continuous mode keeps go; an abort then stops it
    {i_rc_clk_sel, i_in_sleep, i_cont_mode} <= 3'b001;
    tick(2);
    pulse(7'h01);
    tick(40);
    chk(stat & 8'h0c, 8'h0c);
    i_cont_mode <= 1'b0;
    pulse(7'h02);
    pulse(7'h04);
    tick(5);
    chk(stat, 8'h00);
    // Reset in mid-conversion returns everything to rest
    i_sel_wdata <= 8'h1d;
    pulse(7'h41);
    tick(6);
    i_reset <= 1'b1;
    tick(2);
    i_reset <= 1'b0;
    tick(3);
    chk(stat, 8'h00);
    chk(o_sel_rdata, 8'h00);
    summarize();
  end
endmodule // testbench
